// file: rtl/gpio_port_cfg.svh
// Offsets, field positions, reset values and timing counts of the GPIO port block.
// Assumes inclusion by the package and the port module; definitions only.
`ifndef GPIO_PORT_CFG_SVH
`define GPIO_PORT_CFG_SVH

// ---------------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------------
`define PORT0_DATA_OFS    12'h000
`define PORT0_MODE_OFS    12'h004
`define PORT1_DATA_OFS    12'h008
`define PORT1_MODE_OFS    12'h00C
`define PORT_CTRL_OFS     12'h010
`define PORT_SET_OFS      12'h014
`define PORT_STAT_OFS     12'h018
`define PORT_PIN_OFS      12'h01C

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define CTRL_LED_BIT      0
`define CTRL_ROFF_BIT     5
`define CTRL_MATRIX_BIT   6
`define CTRL_STROBE_BIT   7
`define SET_CLKOUT0_BIT   0
`define SET_CLKOUT1_BIT   1
`define SET_CLKEN_BIT     2
`define SET_REFEN_BIT     3
`define SET_XOEN_BIT      4
`define SET_LARGE_BIT     5

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define PORT_DATA_RST     8'hFF
`define PORT_MODE_RST     8'h00

// ---------------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------------
`define CLK_PERIOD_PS     5000
`define WAKE_MIN_NS       10
`define WAKE_CYCLES       ((`WAKE_MIN_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// file: rtl/gpio_port_pkg.sv
// Types shared by the GPIO port block.
// Assumes the constants header sits beside it.
`include "gpio_port_cfg.svh"

package gpio_port_pkg;

    typedef enum logic [1:0] {
        STB_IDLE = 2'b00,
        STB_HIGH = 2'b01
    } strobe_state_t;

    typedef struct packed {
        logic [7:0]    p0_data;
        logic [7:0]    p0_mode;
        logic [1:0]    p1_data;
        logic [1:0]    p1_mode;
        logic [1:0]    led_mode;
        logic          matrix_req;
        logic          roff_req;
        logic          strobe_bit;
        logic [5:0]    special;
        strobe_state_t stb_state;
        logic          wake_seen;
        logic [31:0]   rdata;
        logic          latch_pulse;
    } port_state_t;

    typedef struct packed {
        logic matrix;
        logic roff;
    } pad_opt_t;

endpackage : gpio_port_pkg

// file: rtl/pad_option_latch.sv
// Two-bit pad option latch for the matrix and pull-up disable options.
// Assumes it sits in an always-on supply domain; only the load pulse and
// the option bits come from the core.
`timescale 1ns/1ps

module pad_option_latch
    import gpio_port_pkg::*;
(
    input  wire logic     core_clk_i,
    input  wire logic     rst_i,
    input  wire logic     load_i,
    input  wire pad_opt_t opt_i,
    output pad_opt_t      opt_o
);

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    // Only the power-on reset clears it; core shutdown does not.
    pad_opt_t opt_r;
    pad_opt_t opt_nxt;

    always_comb begin
        opt_nxt = opt_r;
        if (load_i) begin
            opt_nxt = opt_i;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            opt_r <= '0;
        end else begin
            opt_r <= opt_nxt;
        end
    end

    assign opt_o = opt_r;

endmodule : pad_option_latch

// file: rtl/gpio_port.sv
// GPIO port with package pin mapping, drive modes, special roles and pad options.
// Assumes an APB master on core_clk_i and pad cells that resolve pins from the enables.
`timescale 1ns/1ps
`include "gpio_port_cfg.svh"

module gpio_port
    import gpio_port_pkg::*;
#(
    parameter int P0_W = 8,
    parameter int P1_W = 2
) (
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              debug_active_i,
    input  wire logic              debug_data_out_i,
    input  wire logic              debug_data_oe_i,
    input  wire logic              shutdown_i,
    input  wire logic              user_clk_i,
    input  wire logic              ref_clk_i,
    input  wire logic [P0_W+P1_W-1:0] pin_i,
    output logic [P0_W+P1_W-1:0]   pin_o,
    output logic [P0_W+P1_W-1:0]   pin_oe_o,
    output logic [P0_W+P1_W-1:0]   pullup_en_o,
    output logic [P0_W+P1_W-1:0]   pulldown_en_o,
    output logic                   led_sink_en_o,
    output logic [1:0]             led_level_o,
    output logic                   crystal_osc_input_en_o,
    output logic                   debug_clock_line_o,
    output logic                   debug_data_line_o,
    output logic                   wake_o
);
    localparam int NP = P0_W + P1_W;

    // ------------------------------------------------------------------------
    // Pin synchronisers: change counts once stages two and three agree
    // ------------------------------------------------------------------------
    logic [NP-1:0] s1_r, s2_r, s3_r, pin_sync_r;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_r       <= '1;
            s2_r       <= '1;
            s3_r       <= '1;
            pin_sync_r <= '1;
        end else begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < NP; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    pin_sync_r[i] <= s3_r[i];
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // State and APB
    // ------------------------------------------------------------------------
    port_state_t st_r, st_nxt;
    pad_opt_t    opt_latched;
    logic        access, wr, rd, mapped;
    logic        large_pkg;
    logic [NP-1:0] present;

    assign access = psel && penable;
    assign wr     = access && pwrite;
    assign rd     = access && !pwrite;
    assign large_pkg = st_r.special[`SET_LARGE_BIT];
    // Unbonded pins in the small package are never driven nor reported
    assign present = large_pkg ? {NP{1'b1}} : NP'(8'h3F);

    always_comb begin
        mapped = 1'b1;
        case (paddr)
            `PORT0_DATA_OFS, `PORT0_MODE_OFS, `PORT1_DATA_OFS, `PORT1_MODE_OFS,
            `PORT_CTRL_OFS, `PORT_SET_OFS, `PORT_STAT_OFS, `PORT_PIN_OFS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    always_comb begin
        st_nxt             = st_r;
        st_nxt.latch_pulse = 1'b0;
        if (wr) begin
            case (paddr)
                `PORT0_DATA_OFS: st_nxt.p0_data = pwdata[7:0];
                `PORT0_MODE_OFS: st_nxt.p0_mode = pwdata[7:0];
                `PORT1_DATA_OFS: st_nxt.p1_data = pwdata[1:0];
                `PORT1_MODE_OFS: st_nxt.p1_mode = pwdata[1:0];
                `PORT_CTRL_OFS: begin
                    st_nxt.led_mode   = pwdata[`CTRL_LED_BIT +: 2];
                    st_nxt.roff_req   = pwdata[`CTRL_ROFF_BIT];
                    st_nxt.matrix_req = pwdata[`CTRL_MATRIX_BIT];
                    st_nxt.strobe_bit = pwdata[`CTRL_STROBE_BIT];
                end
                `PORT_SET_OFS: st_nxt.special = pwdata[5:0];
                `PORT_STAT_OFS: begin
                    if (pwdata[0]) begin
                        st_nxt.wake_seen = 1'b0;
                    end
                end
                default: st_nxt = st_nxt;
            endcase
        end
        // Strobe 0 -> 1 -> 0 loads the latch with the bits standing at the fall
        case (st_r.stb_state)
            STB_IDLE: begin
                if (st_r.strobe_bit) begin
                    st_nxt.stb_state = STB_HIGH;
                end
            end
            STB_HIGH: begin
                if (!st_r.strobe_bit) begin
                    st_nxt.stb_state   = STB_IDLE;
                    st_nxt.latch_pulse = 1'b1;
                end
            end
            default: st_nxt.stb_state = STB_IDLE;
        endcase
        // Set beats clear when a wake arrives during the clear write
        if (wake_o) begin
            st_nxt.wake_seen = 1'b1;
        end
        st_nxt.rdata = st_r.rdata;
        if (rd) begin
            case (paddr)
                `PORT0_DATA_OFS: st_nxt.rdata = {24'h000000, st_r.p0_data};
                `PORT0_MODE_OFS: st_nxt.rdata = {24'h000000, st_r.p0_mode};
                `PORT1_DATA_OFS: st_nxt.rdata = {30'h00000000, st_r.p1_data};
                `PORT1_MODE_OFS: st_nxt.rdata = {30'h00000000, st_r.p1_mode};
                `PORT_CTRL_OFS: st_nxt.rdata = {24'h000000, st_r.strobe_bit, opt_latched.matrix,
                                                opt_latched.roff, 3'h0, st_r.led_mode};
                `PORT_SET_OFS:  st_nxt.rdata = {26'h0000000, st_r.special};
                `PORT_STAT_OFS: st_nxt.rdata = {31'h00000000, st_r.wake_seen};
                `PORT_PIN_OFS:  st_nxt.rdata = {22'h000000, pin_sync_r & present};
                default:        st_nxt.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r           <= '0;
            st_r.p0_data   <= `PORT_DATA_RST;
            st_r.p0_mode   <= `PORT_MODE_RST;
            st_r.p1_data   <= 2'h3;
            st_r.p1_mode   <= 2'h0;
            st_r.stb_state <= STB_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // One-wait-state slave: read data is registered in the access cycle, so the
    // bus answers the cycle after; pready goes high in the second access cycle.
    logic ready_r;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ready_r <= 1'b0;
        end else begin
            ready_r <= access && !ready_r;
        end
    end
    assign pready  = ready_r;
    assign pslverr = ready_r && !mapped;
    assign prdata  = st_r.rdata;

    // ------------------------------------------------------------------------
    // Pad option latch in the always-on domain
    // ------------------------------------------------------------------------
    pad_opt_t opt_req;
    assign opt_req = {st_r.matrix_req, st_r.roff_req};

    pad_option_latch u_opt (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .load_i     (st_r.latch_pulse),
        .opt_i      (opt_req),
        .opt_o      (opt_latched)
    );

    // ------------------------------------------------------------------------
    // Pad drive per pin
    // ------------------------------------------------------------------------
    logic [NP-1:0] port_val, port_pp;
    assign port_val = {st_r.p1_data, st_r.p0_data};
    assign port_pp  = {st_r.p1_mode, st_r.p0_mode};

    genvar g;
    generate
        for (g = 0; g < NP; g++) begin : g_pin
            logic drv_val, drv_en;
            logic is_matrix, is_roff;
            assign is_matrix = (g >= 1) && (g <= 3) && opt_latched.matrix;
            assign is_roff   = (g >= 1) && (g <= 2) && opt_latched.roff;
            always_comb begin
                drv_val = port_val[g];
                drv_en  = port_pp[g] || !port_val[g];
                if (g == 0) begin
                    drv_en = 1'b0;
                end else if (g == 5) begin
                    drv_en = 1'b0;
                end else if (g == 3 && st_r.special[`SET_REFEN_BIT]) begin
                    drv_val = ref_clk_i;
                    drv_en  = 1'b1;
                end else if (g == 4 && debug_active_i) begin
                    drv_val = debug_data_out_i;
                    drv_en  = debug_data_oe_i;
                end else if ((g == 4 || g == 6) && st_r.special[`SET_CLKEN_BIT]
                             && st_r.special[(g == 4) ? `SET_CLKOUT0_BIT : `SET_CLKOUT1_BIT]) begin
                    drv_val = user_clk_i;
                    drv_en  = 1'b1;
                end
                // Core logic is unpowered in shutdown; drivers are off, only the pull-ups and matrix pull-downs set by the latched options act
                if (shutdown_i) begin
                    drv_en = 1'b0;
                end
                if (!present[g]) begin
                    drv_en = 1'b0;
                end
            end
            assign pin_o[g]         = drv_val;
            assign pin_oe_o[g]      = drv_en;
            assign pullup_en_o[g]   = present[g] && !is_matrix && !is_roff;
            assign pulldown_en_o[g] = present[g] && is_matrix;
        end
    endgenerate

    assign crystal_osc_input_en_o = st_r.special[`SET_XOEN_BIT];
    assign led_sink_en_o      = !debug_active_i && !shutdown_i && !st_r.p0_data[5];
    assign led_level_o        = st_r.led_mode;
    assign debug_clock_line_o = debug_active_i && pin_sync_r[5];
    assign debug_data_line_o  = pin_sync_r[4];

    // Button pins (present pins but the LED pin, less driver pins 1-3 with matrix latched); a key pulls an input low
    logic [NP-1:0] btn_mask;
    assign btn_mask = present & ~NP'(8'h20) & (opt_latched.matrix ? ~NP'(8'h0E) : {NP{1'b1}});
    assign wake_o   = shutdown_i && |(~pin_sync_r & btn_mask);

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    sequence s_strobe_fall;
        st_r.stb_state == STB_HIGH && !st_r.strobe_bit;
    endsequence

    a_strobe_loads: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_strobe_fall |=> ##1 (opt_latched.matrix == $past(st_r.matrix_req)
                               && opt_latched.roff == $past(st_r.roff_req)))
        else $error("option latch not loaded on strobe fall");
    a_pin0_input: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !pin_oe_o[0]) else $error("pin 0 driven");
    a_led_debug_off: assert property (@(posedge core_clk_i) disable iff (rst_i)
        debug_active_i |-> !led_sink_en_o && !pin_oe_o[5]) else $error("LED on in debug");
    a_matrix_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (shutdown_i && opt_latched.matrix) |-> pulldown_en_o[3:1] == 3'b111 && pin_oe_o[3:1] == 3'b000)
        else $error("matrix pins not held low");
    a_roff_pullup: assert property (@(posedge core_clk_i) disable iff (rst_i)
        opt_latched.roff |-> pullup_en_o[2:1] == 2'b00 && pullup_en_o[0] == 1'b1)
        else $error("pull-up disable wrong");
    a_ctrl_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (rd && paddr == `PORT_CTRL_OFS) |=> prdata[`CTRL_MATRIX_BIT] == $past(opt_latched.matrix))
        else $error("control read not from latch");
    a_wake_button: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (shutdown_i && !pin_sync_r[2] && !opt_latched.matrix) |-> wake_o) else $error("no wake on press");
    a_small_pkg: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !large_pkg |-> pin_oe_o[NP-1:6] == '0) else $error("unbonded pin driven");
    a_open_drain: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (!shutdown_i && !st_r.p0_mode[1] && st_r.p0_data[1]) |-> !pin_oe_o[1])
        else $error("open-drain pin drives high");
    a_clkout_pin6: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (!shutdown_i && large_pkg && st_r.special[`SET_CLKEN_BIT] && st_r.special[`SET_CLKOUT1_BIT])
        |-> pin_oe_o[6] && pin_o[6] == user_clk_i) else $error("clock out missing on pin 6");

endmodule : gpio_port

// file: bench/button_pad_model.sv
// Far-side model of the port: buttons to ground and a 3x2 key matrix.
// Assumes the port drives pin levels, enables and resistor controls combinationally.
`timescale 1ns/1ps

module button_pad_model (
    input  wire logic       core_clk_i,
    input  wire logic [9:0] pin_o_i,
    input  wire logic [9:0] pin_oe_i,
    input  wire logic [9:0] pullup_en_i,
    input  wire logic [9:0] pulldown_en_i,
    input  wire logic [9:0] button_i,
    input  wire logic [5:0] key_i,
    output logic      [9:0] pin_level_o
);
    logic       float_r = 1'b0;
    logic [3:1] drv_low;

    // An undriven, unpulled pad wanders so a stale level never reads as valid
    always_ff @(posedge core_clk_i) begin
        float_r <= ~float_r;
    end

    always_comb begin
        for (int d = 1; d <= 3; d++) begin
            drv_low[d] = pin_oe_i[d] ? !pin_o_i[d] : pulldown_en_i[d];
        end
        for (int k = 0; k < 10; k++) begin
            if (pin_oe_i[k]) begin
                pin_level_o[k] = pin_o_i[k];
            end else if (button_i[k]) begin
                pin_level_o[k] = 1'b0;
            end else if (pullup_en_i[k]) begin
                pin_level_o[k] = 1'b1;
            end else if (pulldown_en_i[k]) begin
                pin_level_o[k] = 1'b0;
            end else begin
                pin_level_o[k] = float_r ^ k[0];
            end
        end
        // Key (d,c) joins driver pin d to column pin 4 (c=0) or pin 0 (c=1)
        for (int d = 1; d <= 3; d++) begin
            if (key_i[2*d-2] && drv_low[d] && !pin_oe_i[4]) pin_level_o[4] = 1'b0;
            if (key_i[2*d-1] && drv_low[d] && !pin_oe_i[0]) pin_level_o[0] = 1'b0;
        end
    end
endmodule : button_pad_model

// file: bench/testbench.sv
// Self-checking bench for the GPIO port: APB master tasks, one task per scenario.
// Assumes the port's register map header and the pad model beside it.
`timescale 1ns/1ps
`include "gpio_port_cfg.svh"

module testbench;
    logic        core_clk_i = 1'b0;
    logic        rst_i      = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr  = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic        pready, pslverr, err_seen;
    logic        dbg_act = 1'b0, shutdown = 1'b0, user_clk = 1'b0;
    logic [9:0]  btn = 10'h000, pin_lvl, pin_o, pin_oe, pu, pd;
    logic [5:0]  key = 6'h00;
    logic        led_en, xo_en, wake;
    logic        dbg_clk;
    logic [1:0]  led_lvl;
    int          bad_count = 0;
    int          cmp_count = 0;

    always #2.5 core_clk_i = ~core_clk_i;

    gpio_port dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .debug_active_i(dbg_act), .debug_data_out_i(1'b0), .debug_data_oe_i(1'b0), .shutdown_i(shutdown),
        .user_clk_i(user_clk), .ref_clk_i(1'b0), .pin_i(pin_lvl), .pin_o(pin_o), .pin_oe_o(pin_oe),
        .pullup_en_o(pu), .pulldown_en_o(pd), .led_sink_en_o(led_en), .led_level_o(led_lvl),
        .crystal_osc_input_en_o(xo_en), .debug_clock_line_o(dbg_clk), .debug_data_line_o(), .wake_o(wake));

    button_pad_model pad_u (.core_clk_i(core_clk_i), .pin_o_i(pin_o), .pin_oe_i(pin_oe), .pullup_en_i(pu),
        .pulldown_en_i(pd), .button_i(btn), .key_i(key), .pin_level_o(pin_lvl));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n = 0;
        @(posedge core_clk_i);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge core_clk_i);
        penable <= 1'b1;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdv      = prdata;
        err_seen = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) chk("pready", 32'h0, 32'h1);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask : rd

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : tick

    task automatic latch_opt(input logic [7:0] c);
        wr(`PORT_CTRL_OFS, {24'h0, c & 8'h7F});
        wr(`PORT_CTRL_OFS, {24'h0, c | 8'h80});
        wr(`PORT_CTRL_OFS, {24'h0, c & 8'h7F});
        tick(3);
    endtask : latch_opt

    task automatic wait_wake();
        int n = 0;
        while (wake !== 1'b1 && n < 20) begin
            @(posedge core_clk_i);
            n++;
        end
        #1;
    endtask : wait_wake

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rd(`PORT0_DATA_OFS); chk("p0 data", rdv, 32'hFF);
        rd(`PORT0_MODE_OFS); chk("p0 mode", rdv, 32'h00);
        rd(`PORT1_DATA_OFS); chk("p1 data", rdv, 32'h03);
        chk("oe after reset", pin_oe, 10'h000);
        chk("small pullups", pu, 10'h03F);
        rd(12'h020);
        chk("unmapped rdata", rdv, 32'h0);
        chk("unmapped err", err_seen, 1'b1);
    endtask : t_reset

    task automatic t_drive();
        wr(`PORT0_DATA_OFS, 32'hEA);
        wr(`PORT0_MODE_OFS, 32'h0D);
        tick(1);
        chk("oe 4..1", pin_oe[4:1], 4'hE);
        chk("out 4..2", pin_o[4:2], 3'b010);
        chk("pin0 never drives", pin_oe[0], 1'b0);
        wr(`PORT0_DATA_OFS, 32'hFF);
        wr(`PORT0_MODE_OFS, 32'h00);
        wr(`PORT_SET_OFS, 32'h30);
        wr(`PORT1_MODE_OFS, 32'h3);
        wr(`PORT1_DATA_OFS, 32'h2);
        tick(2);
        chk("large pullups", pu[9:6], 4'hF);
        chk("port1 pins", {pin_oe[9:8], pin_o[9:8]}, 4'hE);
        chk("xo enable", xo_en, 1'b1);
        wr(`PORT1_MODE_OFS, 32'h0);
        wr(`PORT1_DATA_OFS, 32'h3);
        wr(`PORT_SET_OFS, 32'h00);
        tick(2);
        chk("xo disable", xo_en, 1'b0);
    endtask : t_drive

    task automatic t_led_clk();
        logic [1:0] cfg;
        wr(`PORT0_DATA_OFS, 32'hDF);
        tick(1);
        chk("led on", led_en, 1'b1);
        wr(`PORT_CTRL_OFS, 32'h02);
        tick(1);
        chk("led level", led_lvl, 2'h2);
        @(posedge core_clk_i);
        dbg_act <= 1'b1;
        tick(2);
        chk("led off in debug", led_en, 1'b0);
        chk("debug clock line", dbg_clk, 1'b1);
        @(posedge core_clk_i);
        dbg_act <= 1'b0;
        wr(`PORT0_DATA_OFS, 32'hFF);
        chk("debug clock idle", dbg_clk, 1'b0);
        for (int c = 1; c <= 3; c++) begin
            cfg = c[1:0];
            wr(`PORT_SET_OFS, {26'h0, 4'h9, cfg});
            for (int v = 0; v < 2; v++) begin
                @(posedge core_clk_i);
                user_clk <= v[0];
                tick(1);
                chk("clk out en", {pin_oe[6], pin_oe[4]}, cfg);
                chk("clk out lvl", {pin_o[6] & pin_oe[6], pin_o[4] & pin_oe[4]}, cfg & {2{v[0]}});
            end
        end
        wr(`PORT_SET_OFS, 32'h00);
    endtask : t_led_clk

    task automatic t_roff();
        wr(`PORT_CTRL_OFS, 32'h20);
        tick(3);
        rd(`PORT_CTRL_OFS); chk("ctrl unlatched", rdv[6:5], 2'b00);
        chk("pullups kept", pu[3:0], 4'hF);
        latch_opt(8'h20);
        rd(`PORT_CTRL_OFS); chk("ctrl latched", rdv[6:5], 2'b01);
        chk("roff pullups", pu[3:0], 4'h9);
        latch_opt(8'h00);
        chk("pullups back", pu[3:0], 4'hF);
    endtask : t_roff

    task automatic t_matrix();
        logic [2:0] pat;
        wr(`PORT0_DATA_OFS, 32'hFF);
        wr(`PORT0_MODE_OFS, 32'h00);
        latch_opt(8'h40);
        chk("matrix resistors", {pu[3:0], pd[3:0]}, 8'h1E);
        @(posedge core_clk_i);
        shutdown <= 1'b1;
        tick(8);
        chk("drivers low", {wake, pin_lvl[3:1]}, 4'h0);
        @(posedge core_clk_i);
        key <= 6'h04;
        wait_wake(); chk("matrix wake", wake, 1'b1);
        @(posedge core_clk_i);
        shutdown <= 1'b0;
        latch_opt(8'h00);
        for (int i = 0; i < 4; i++) begin
            pat = (i == 3) ? 3'b111 : ~(3'b001 << i);
            wr(`PORT0_DATA_OFS, {24'h0, 4'hF, pat, 1'b1});
            tick(6);
            rd(`PORT_PIN_OFS); chk("scan cols", {rdv[4], rdv[0]}, {pat[1], 1'b1});
        end
        key <= 6'h00;
        wr(`PORT0_DATA_OFS, 32'hFF);
    endtask : t_matrix

    task automatic t_wake();
        wr(`PORT_STAT_OFS, 32'h1);
        rd(`PORT_STAT_OFS);
        chk("wake clear first", rdv[0], 1'b0);
        shutdown <= 1'b1;
        tick(6);
        chk("no wake idle", wake, 1'b0);
        @(posedge core_clk_i);
        btn <= 10'h004;
        wait_wake(); chk("button wake", wake, 1'b1);
        @(posedge core_clk_i);
        btn <= 10'h000;
        shutdown <= 1'b0;
        rd(`PORT_STAT_OFS); chk("wake seen", rdv[0], 1'b1);
        wr(`PORT_STAT_OFS, 32'h1);
        rd(`PORT_STAT_OFS); chk("wake cleared", rdv[0], 1'b0);
    endtask : t_wake

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    initial begin
        #200000;
        bad_count++;
        give_verdict();
    end

    initial begin
        repeat (4) @(posedge core_clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_drive();
        t_led_clk();
        t_roff();
        t_matrix();
        t_wake();
        give_verdict();
    end
endmodule : testbench
